// File: common/eeprom_ctrl_pkg.sv
// package: register offsets, field positions, reset values and timing for the data eeprom controller
package eeprom_ctrl_pkg;

	// register offsets on the plain register port
	localparam logic [3:0] OFF_DATA      = 4'h0;
	localparam logic [3:0] OFF_ADDR      = 4'h1;
	localparam logic [3:0] OFF_CONTROL   = 4'h2;
	localparam logic [3:0] OFF_UNLOCK    = 4'h3;
	localparam logic [3:0] OFF_IRQ_FLAGS = 4'h4;
	localparam logic [3:0] OFF_IRQ_EN    = 4'h5;
	localparam logic [3:0] OFF_GLOBAL    = 4'h6;

	// eeprom_control bit positions
	localparam int CTL_READ_START  = 0;
	localparam int CTL_WRITE_START = 1;
	localparam int CTL_WRITE_ALLOW = 2;
	localparam int CTL_WRITE_ABORT = 3;
	// interrupt flag / enable bit 7, global control bits 7 and 6
	localparam int IRQ_WRITE_DONE  = 7;
	localparam int GLB_GLOBAL_EN   = 7;
	localparam int GLB_PERIPH_EN   = 6;

	// reset values
	localparam logic [7:0] RST_DATA      = 8'h00;
	localparam logic [7:0] RST_ADDR      = 8'h00;
	localparam logic [7:0] RST_IRQ       = 8'h00;
	localparam logic [7:0] RST_GLOBAL    = 8'h00;

	// unlock keys
	localparam logic [7:0] UNLOCK_KEY1   = 8'h55;
	localparam logic [7:0] UNLOCK_KEY2   = 8'hAA;

	// timing at 20 MHz
	localparam int CLK_HZ          = 20_000_000;
	localparam int POWERUP_MS      = 64;
	localparam int POWERUP_CYCLES  = CLK_HZ / 1000 * POWERUP_MS;
	localparam int PROG_MS         = 5;
	localparam int PROG_CYCLES     = CLK_HZ / 1000 * PROG_MS;
	// unlock sequence: at most this many idle cycles may separate one step from the next
	localparam int UNLOCK_GAP      = 4;

	// register port request
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} reg_req_t;

	// array access toward the memory
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       we;
	} mem_req_t;

endpackage

// File: hw/cycle_timer.sv
// down counter that reports when a loaded cycle count has elapsed
`timescale 1ns/1ns
`default_nettype none
module cycle_timer
#(
	parameter int WIDTH = 22
)
(
	// clock and reset
	input  wire logic             sys_clk,
	input  wire logic             rst_n,
	// control
	input  wire logic             load,
	input  wire logic [WIDTH-1:0] count,
	output logic                  busy
);
	logic [WIDTH-1:0] remain;
	logic [WIDTH-1:0] next_remain;

	// load wins over counting
	always_comb
	begin
		next_remain = remain;
		if (load)
			next_remain = count;
		else if (remain != '0)
			next_remain = remain - WIDTH'(1);
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
			remain <= '0;
		else
			remain <= next_remain;
	end

	assign busy = (remain != '0);
endmodule // cycle_timer
`default_nettype wire

// File: hw/eeprom_array.sv
// byte-wide data eeprom array model, 256 locations
`timescale 1ns/1ns
`default_nettype none
module eeprom_array
(
	// clock
	input  wire logic                       sys_clk,
	// access
	input  wire eeprom_ctrl_pkg::mem_req_t  req,
	output logic [7:0]                      rdata
);
	logic [7:0] cells [0:255];

	// write stores, read is combinational so the controller can latch in one cycle
	always_ff @(posedge sys_clk)
	begin
		if (req.we)
			cells[req.addr] <= req.wdata;
	end

	assign rdata = cells[req.addr];
endmodule // eeprom_array
`default_nettype wire

// File: hw/eeprom_ctrl.sv
// data eeprom access controller: registers, unlock guard, power-up lockout, write timing
// Operation
// - write allow bit clears at every power-up, blocking writes until software sets it
// - no write starts while the power-up timer still runs
// - write starts only with write allow set and exact unlock sequence done
// - data memory protect never restricts this cpu-side access path
// - array is 256 bytes, one byte per address
// - unlock port stores nothing and reads as zero
// - 55h then AAh to unlock port then write start; any deviation suppresses
// - read start loads addressed byte next cycle and clears itself
// - write completion clears write start, sets done flag; only software or a reset clears flag
// - reset during a write sets abort flag and clears data and address
`timescale 1ns/1ns
`default_nettype none
module eeprom_ctrl
#(
	parameter int POWERUP_CYCLES = eeprom_ctrl_pkg::POWERUP_CYCLES,
	parameter int PROG_CYCLES    = eeprom_ctrl_pkg::PROG_CYCLES
)
(
	// clock and reset
	input  wire logic                       sys_clk,
	input  wire logic                       rst_n,
	// reset cause: high when the reset is power-on, low for clear, watchdog or brown-out
	input  wire logic                       power_on_rst,
	// configuration fuse, active low protects against outside access only
	input  wire logic                       data_memory_protect_n,
	// register port
	input  wire logic [3:0]                 reg_addr,
	input  wire logic [7:0]                 reg_wdata,
	input  wire logic                       reg_wr,
	input  wire logic                       reg_rd,
	output logic [7:0]                      reg_rdata,
	// status
	output logic                            write_busy,
	output logic                            irq
);
	localparam int TW = 22;

	typedef enum {ULK_IDLE, ULK_KEY1, ULK_KEY2} unlock_t;

	eeprom_ctrl_pkg::reg_req_t req;
	eeprom_ctrl_pkg::mem_req_t mem;
	logic [7:0] mem_rdata;

	// software-visible register state
	logic [7:0] data_byte;
	logic [7:0] next_data_byte;
	logic [7:0] addr_byte;
	logic [7:0] next_addr_byte;
	logic       write_allow;
	logic       next_write_allow;
	logic       write_start;
	logic       next_write_start;
	logic       write_abort_flag;
	logic       next_write_abort_flag;
	logic       write_done_flag;
	logic       next_write_done_flag;
	logic [6:0] irq_flags_other;
	logic [6:0] next_irq_flags_other;
	logic [7:0] irq_enables;
	logic [7:0] next_irq_enables;
	logic [7:0] global_ctl;
	logic [7:0] next_global_ctl;
	// read data register
	logic [7:0] rdata;
	logic [7:0] next_rdata;
	// unlock sequencer
	unlock_t    ulk;
	unlock_t    next_ulk;
	logic [2:0] gap;
	logic [2:0] next_gap;
	// reset history and write timing
	logic       first;
	logic       next_first;
	logic       was_power_on;
	logic       next_was_power_on;
	logic       prog_load;
	logic       prog_busy;
	logic       pwrup_busy;
	logic       start_ok;
	logic       prog_end;
	logic       next_prog_end;

	assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

	// address hit on a write strobe
	// only write strobes matter here; reads change no register other than the unlock sequencer and read data
	function automatic logic hit(input eeprom_ctrl_pkg::reg_req_t r, input logic [3:0] off);
		hit = r.wr && (r.addr == off);
	endfunction

	// power-up lockout, restarted only by power-on reset
	// the first cycle after release is not covered, but write allow is clear then
	cycle_timer #(.WIDTH(TW)) pwrup_timer
	(
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.load    (first && was_power_on),
		.count   (TW'(POWERUP_CYCLES)),
		.busy    (pwrup_busy)
	);

	// array programming time
	// programming time is a parameter; the array model itself writes in one cycle
	cycle_timer #(.WIDTH(TW)) prog_timer
	(
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.load    (prog_load),
		.count   (TW'(PROG_CYCLES)),
		.busy    (prog_busy)
	);

	// protect fuse is deliberately unused here: the cpu path stays open
	eeprom_array array_i
	(
		.sys_clk (sys_clk),
		.req     (mem),
		.rdata   (mem_rdata)
	);

	// the write-start request is legal only when the unlock keys were just seen;
	// write allow is the stored bit, so an earlier control write must have set it
	assign start_ok = hit(req, eeprom_ctrl_pkg::OFF_CONTROL) && req.wdata[eeprom_ctrl_pkg::CTL_WRITE_START]
		&& !write_start && write_allow && (ulk == ULK_KEY2) && !pwrup_busy;
	// timer loads on the edge that sets write start, so busy and timing line up
	assign prog_load = start_ok;
	// array is written once, in the cycle after the timer has run out
	assign mem = '{addr: addr_byte, wdata: data_byte, we: prog_end};

	// unlock sequencer: strict order with a short cycle window between steps
	// a read also breaks the sequence, so nothing else may touch the port between keys
	always_comb
	begin
		next_ulk = ulk;
		next_gap = gap;
		if (req.wr || req.rd)
		begin
			if (hit(req, eeprom_ctrl_pkg::OFF_UNLOCK) && req.wdata == eeprom_ctrl_pkg::UNLOCK_KEY1)
				next_ulk = ULK_KEY1;
			else if (hit(req, eeprom_ctrl_pkg::OFF_UNLOCK) && req.wdata == eeprom_ctrl_pkg::UNLOCK_KEY2
				&& ulk == ULK_KEY1)
				next_ulk = ULK_KEY2;
			else
				next_ulk = ULK_IDLE;
			next_gap = '0;
		end
		else if (ulk != ULK_IDLE)
		begin
			// too many idle cycles between steps breaks the sequence
			if (gap == 3'(eeprom_ctrl_pkg::UNLOCK_GAP))
				next_ulk = ULK_IDLE;
			else
				next_gap = gap + 3'h1;
		end
		case (ulk)
			ULK_IDLE, ULK_KEY1, ULK_KEY2: ;
			default: next_ulk = ULK_IDLE;
		endcase
	end

	// sequencer state; any reset forgets a half-finished unlock
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			ulk <= ULK_IDLE;
			gap <= 3'h0;
		end
		else
		begin
			ulk <= next_ulk;
			gap <= next_gap;
		end
	end

	// register next values
	always_comb
	begin
		next_data_byte        = data_byte;
		next_addr_byte        = addr_byte;
		next_write_allow      = write_allow;
		next_write_start      = write_start;
		next_write_abort_flag = write_abort_flag;
		next_write_done_flag  = write_done_flag;
		next_irq_flags_other  = irq_flags_other;
		next_irq_enables      = irq_enables;
		next_global_ctl       = global_ctl;
		next_first            = 1'b0;
		next_was_power_on     = was_power_on;
		// one-cycle end pulse once the programming timer has drained
		next_prog_end         = write_start && prog_busy == 1'b0 && !prog_load && !prog_end;

		// cpu writes; data and address locked while a write runs
		// a locked write is dropped silently; there is no error bit for it
		if (hit(req, eeprom_ctrl_pkg::OFF_DATA) && !write_start)
			next_data_byte = req.wdata;
		if (hit(req, eeprom_ctrl_pkg::OFF_ADDR) && !write_start)
			next_addr_byte = req.wdata;
		if (hit(req, eeprom_ctrl_pkg::OFF_CONTROL))
		begin
			next_write_allow      = req.wdata[eeprom_ctrl_pkg::CTL_WRITE_ALLOW];
			next_write_abort_flag = req.wdata[eeprom_ctrl_pkg::CTL_WRITE_ABORT];
			// read start loads the byte at once and never stays visible
			if (req.wdata[eeprom_ctrl_pkg::CTL_READ_START] && !write_start)
				next_data_byte = mem_rdata;
		end
		if (start_ok)
			next_write_start = 1'b1;
		if (hit(req, eeprom_ctrl_pkg::OFF_IRQ_FLAGS))
		begin
			next_write_done_flag = req.wdata[eeprom_ctrl_pkg::IRQ_WRITE_DONE];
			next_irq_flags_other = req.wdata[6:0];
		end
		if (hit(req, eeprom_ctrl_pkg::OFF_IRQ_EN))
			next_irq_enables = req.wdata;
		if (hit(req, eeprom_ctrl_pkg::OFF_GLOBAL))
			next_global_ctl = req.wdata;

		// completion: hardware clears start, done flag set wins over a software clear
		if (prog_end)
		begin
			next_write_start     = 1'b0;
			next_write_done_flag = 1'b1;
		end
	end

	// read data, one cycle after the strobe; unlock port reads zero
	// registered so the answer stands one cycle and the port idles at zero
	always_comb
	begin
		next_rdata = 8'h00;
		if (req.rd)
		begin
			case (req.addr)
				eeprom_ctrl_pkg::OFF_DATA:      next_rdata = data_byte;
				eeprom_ctrl_pkg::OFF_ADDR:      next_rdata = addr_byte;
				eeprom_ctrl_pkg::OFF_CONTROL:   next_rdata = {4'h0, write_abort_flag, write_allow, write_start, 1'b0};
				eeprom_ctrl_pkg::OFF_UNLOCK:    next_rdata = 8'h00;
				eeprom_ctrl_pkg::OFF_IRQ_FLAGS: next_rdata = {write_done_flag, irq_flags_other};
				eeprom_ctrl_pkg::OFF_IRQ_EN:    next_rdata = irq_enables;
				eeprom_ctrl_pkg::OFF_GLOBAL:    next_rdata = global_ctl;
				default:                        next_rdata = 8'h00;
			endcase
		end
	end

	// registers; reset during a write records the abort and wipes data/address
	// the abort flag is the one field whose reset value depends on what reset cut
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			data_byte        <= eeprom_ctrl_pkg::RST_DATA;
			addr_byte        <= eeprom_ctrl_pkg::RST_ADDR;
			write_allow      <= 1'b0;
			write_start      <= 1'b0;
			// abort flag set by a reset that cut a write short; otherwise kept, but cleared by power-on
			write_abort_flag <= write_start ? 1'b1 : (power_on_rst ? 1'b0 : write_abort_flag);
			write_done_flag  <= 1'b0;
			irq_flags_other  <= 7'h00;
			irq_enables      <= eeprom_ctrl_pkg::RST_IRQ;
			global_ctl       <= eeprom_ctrl_pkg::RST_GLOBAL;
			first            <= 1'b1;
			was_power_on     <= power_on_rst;
			prog_end         <= 1'b0;
		end
		else
		begin
			data_byte        <= next_data_byte;
			addr_byte        <= next_addr_byte;
			write_allow      <= next_write_allow;
			write_start      <= next_write_start;
			write_abort_flag <= next_write_abort_flag;
			write_done_flag  <= next_write_done_flag;
			irq_flags_other  <= next_irq_flags_other;
			irq_enables      <= next_irq_enables;
			global_ctl       <= next_global_ctl;
			first            <= next_first;
			was_power_on     <= next_was_power_on;
			prog_end         <= next_prog_end;
		end
	end

	// read data register
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
			rdata <= 8'h00;
		else
			rdata <= next_rdata;
	end

	// outputs
	assign reg_rdata  = rdata;
	// busy mirrors write start, so pin and register always agree
	assign write_busy = write_start;
	// interrupt gated by enable, peripheral and global enables
	assign irq = write_done_flag && irq_enables[eeprom_ctrl_pkg::IRQ_WRITE_DONE]
		&& global_ctl[eeprom_ctrl_pkg::GLB_PERIPH_EN] && global_ctl[eeprom_ctrl_pkg::GLB_GLOBAL_EN];
endmodule // eeprom_ctrl
`default_nettype wire

// File: tb/eeprom_ctrl_monitor.sv
// port checker for the data eeprom controller
`timescale 1ns/1ns
`default_nettype none
module eeprom_ctrl_monitor
#(
	parameter int POWERUP_CYCLES = 50,
	parameter int PROG_CYCLES    = 20
)
(
	// clock, reset, fuse
	input wire logic       sys_clk,
	input wire logic       rst_n,
	input wire logic       power_on_rst,
	input wire logic       data_memory_protect_n,
	// register port and status
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic       write_busy,
	input wire logic       irq
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	int   up_cnt;
	int   busy_len;
	logic pu_armed;
	logic en_irq;
	logic en_glb;
	logic allow_seen;
	// lockout age, busy length, enable shadows; age saturates so it never wraps
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			pu_armed <= power_on_rst;
			up_cnt <= 0;
			busy_len <= 0;
			en_irq <= 1'b0;
			en_glb <= 1'b0;
			allow_seen <= 1'b0;
		end
		else
		begin
			up_cnt <= (up_cnt > POWERUP_CYCLES + 8) ? up_cnt : up_cnt + 1;
			busy_len <= write_busy ? busy_len + 1 : 0;
			if (reg_wr && reg_addr == eeprom_ctrl_pkg::OFF_IRQ_EN)
				en_irq <= reg_wdata[7];
			if (reg_wr && reg_addr == eeprom_ctrl_pkg::OFF_GLOBAL)
				en_glb <= reg_wdata[7] & reg_wdata[6];
			if (reg_wr && reg_addr == eeprom_ctrl_pkg::OFF_CONTROL)
				allow_seen <= reg_wdata[2];
		end
	end
	// the three steps of a write start
	sequence key1_s;
		reg_wr && reg_addr == eeprom_ctrl_pkg::OFF_UNLOCK && reg_wdata == eeprom_ctrl_pkg::UNLOCK_KEY1;
	endsequence
	sequence key2_s;
		reg_wr && reg_addr == eeprom_ctrl_pkg::OFF_UNLOCK && reg_wdata == eeprom_ctrl_pkg::UNLOCK_KEY2;
	endsequence
	sequence start_s;
		reg_wr && reg_addr == eeprom_ctrl_pkg::OFF_CONTROL && reg_wdata[1] && allow_seen;
	endsequence
	rst_clear_a: assert property (disable iff (1'b0) !rst_n |=> !write_busy && !irq && reg_rdata == 8'h00)
		else $error("outputs not cleared by reset");
	lockout_a: assert property (pu_armed && up_cnt < POWERUP_CYCLES - 2 |-> !$rose(write_busy))
		else $error("write started during power-up lockout");
	start_cause_a: assert property ($rose(write_busy) |-> $past(reg_wr && reg_addr == 4'h2 && reg_wdata[1]))
		else $error("write started without a start request");
	unlock_ok_a: assert property ((!write_busy && (!pu_armed || up_cnt > POWERUP_CYCLES + 2)) ##0 key1_s ##1 key2_s ##1 start_s |=> write_busy)
		else $error("exact unlock did not start a write");
	prog_time_a: assert property ($fell(write_busy) |-> busy_len >= PROG_CYCLES - 2 && busy_len <= PROG_CYCLES + 2)
		else $error("write cycle length wrong");
	done_irq_a: assert property ($fell(write_busy) && en_irq && en_glb |-> ##[0:1] irq)
		else $error("no interrupt at write completion");
	irq_hold_a: assert property (irq && !reg_wr |=> irq)
		else $error("done flag cleared without software");
	unlock_zero_a: assert property (reg_rd && reg_addr == eeprom_ctrl_pkg::OFF_UNLOCK |=> reg_rdata == 8'h00)
		else $error("unlock port read not zero");
endmodule // eeprom_ctrl_monitor

bind eeprom_ctrl eeprom_ctrl_monitor #(.POWERUP_CYCLES(POWERUP_CYCLES), .PROG_CYCLES(PROG_CYCLES)) eeprom_ctrl_monitor_i (
	.sys_clk(sys_clk), .rst_n(rst_n), .power_on_rst(power_on_rst), .data_memory_protect_n(data_memory_protect_n),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.write_busy(write_busy), .irq(irq));
`default_nettype wire

// File: tb/tb.sv
// self-checking bench for the data eeprom controller
`timescale 1ns/1ns
`default_nettype none
module tb;
	logic       sys_clk, rst_n, power_on_rst, data_memory_protect_n;
	logic       reg_wr, reg_rd, write_busy, irq, rd_q;
	logic [3:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, a0;
	logic [7:0] exp_q[$];
	logic [7:0] dd[2];
	logic [7:0] bad[4][4];
	int         n_mismatch;
	int         num_checks;

	eeprom_ctrl #(.POWERUP_CYCLES(50), .PROG_CYCLES(20)) eeprom_ctrl_i (
		.sys_clk(sys_clk), .rst_n(rst_n), .power_on_rst(power_on_rst),
		.data_memory_protect_n(data_memory_protect_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .write_busy(write_busy), .irq(irq));

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("FAIL %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	// one bus cycle, launched just after an edge
	task automatic cyc(input logic w, input logic r, input logic [3:0] a, input logic [7:0] d);
		reg_wr <= w;
		reg_rd <= r;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
	endtask
	task automatic idle(input int n);
		repeat (n) cyc(1'b0, 1'b0, 4'h0, 8'h00);
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		cyc(1'b1, 1'b0, a, d);
	endtask
	// expectation is noted before the strobe goes out
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		cyc(1'b0, 1'b1, a, 8'h00);
	endtask
	// write allow is a stored bit, so it is set before the keys go out
	task automatic unlock(input logic [7:0] c);
		wr(4'h2, 8'h04);
		wr(4'h3, eeprom_ctrl_pkg::UNLOCK_KEY1);
		wr(4'h3, eeprom_ctrl_pkg::UNLOCK_KEY2);
		wr(4'h2, c);
	endtask
	// extra idle cycle keeps requests off the release edge
	task automatic reset(input logic po);
		power_on_rst <= po;
		rst_n <= 1'b0;
		idle(3);
		rst_n <= 1'b1;
		idle(1);
	endtask
	task automatic wait_done;
		for (int i = 0; i < 100 && write_busy !== 1'b0; i++)
			idle(1);
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// read answers stand one cycle after the strobe
	always @(posedge sys_clk)
	begin
		if (rd_q === 1'b1)
			check(reg_rdata, exp_q.pop_front());
		rd_q <= reg_rd;
	end
	initial
	begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	// run needs a few hundred cycles
	initial
	begin
		repeat (3000) @(posedge sys_clk);
		n_mismatch++;
		$display("FAIL %0t: timeout", $time);
		summarize();
	end
	initial
	begin
		n_mismatch = 0;
		num_checks = 0;
		data_memory_protect_n = 1'b1;
		bad = '{'{8'hAA, 8'h55, 8'h06, 8'h00}, '{8'h55, 8'h55, 8'h06, 8'h00},
			'{8'h55, 8'hAA, 8'h02, 8'h00}, '{8'h55, 8'hAA, 8'h06, 8'h05}};
		a0 = 8'($urandom(32'h36A9954E));
		reset(1'b1);
		for (int i = 0; i < 16; i++)
			if (i < 7 || i == 15)
				rd(4'(i), 8'h00);
		$display("test done: reset values");
		wr(eeprom_ctrl_pkg::OFF_IRQ_EN, 8'h80);
		wr(eeprom_ctrl_pkg::OFF_GLOBAL, 8'hC0);
		unlock(8'h06);
		idle(1);
		check({7'h00, write_busy}, 8'h00);
		rd(4'h2, 8'h04);
		idle(60);
		$display("test done: lockout");
		for (int i = 0; i < 4; i++)
		begin
			wr(4'h2, bad[i][2] & 8'h04);
			wr(4'h3, bad[i][0]);
			idle(int'(bad[i][3]));
			wr(4'h3, bad[i][1]);
			wr(4'h2, bad[i][2]);
			idle(1);
			check({7'h00, write_busy}, 8'h00);
			rd(4'h2, bad[i][2] & 8'h04);
		end
		$display("test done: bad unlock");
		data_memory_protect_n <= 1'b0;
		for (int k = 0; k < 2; k++)
		begin
			dd[k] = 8'($urandom());
			wr(4'h1, a0 ^ 8'(k));
			wr(4'h0, dd[k]);
			unlock(8'h06);
			idle(1);
			check({7'h00, write_busy}, 8'h01);
			wr(4'h0, ~dd[k]);
			rd(4'h2, 8'h06);
			wr(4'h2, 8'h00);
			rd(4'h2, 8'h02);
			wait_done();
			check({7'h00, irq}, 8'h01);
			rd(eeprom_ctrl_pkg::OFF_IRQ_FLAGS, 8'h80);
			rd(4'h0, dd[k]);
			wr(eeprom_ctrl_pkg::OFF_IRQ_FLAGS, 8'h00);
			idle(1);
			check({7'h00, irq}, 8'h00);
		end
		for (int k = 0; k < 2; k++)
		begin
			wr(4'h1, a0 ^ 8'(k));
			wr(4'h2, 8'h01);
			rd(4'h0, dd[k]);
			rd(4'h2, 8'h00);
		end
		$display("test done: write and read back");
		unlock(8'h06);
		idle(3);
		reset(1'b0);
		rd(4'h2, 8'h08);
		rd(4'h0, 8'h00);
		rd(4'h1, 8'h00);
		unlock(8'h06);
		idle(1);
		check({7'h00, write_busy}, 8'h01);
		wait_done();
		reset(1'b1);
		rd(4'h2, 8'h00);
		idle(2);
		$display("test done: abort by reset");
		summarize();
	end
endmodule // tb
`default_nettype wire
